/* File: common/jsr_defines.svh */
// constants for the scan and identification register set
`ifndef JSR_DEFINES_SVH
`define JSR_DEFINES_SVH

`define JSR_IR_LEN 10
`define JSR_IR_CAPTURE 10'h001
`define JSR_OP_EXTEST 10'h000
`define JSR_OP_SAMPLE 10'h005
`define JSR_OP_IDCODE 10'h006
`define JSR_OP_USERCODE 10'h007
`define JSR_OP_CLAMP 10'h00a
`define JSR_OP_HIGHZ 10'h00b
`define JSR_OP_BYPASS 10'h3ff

`define JSR_WORD_LEN 32
`define JSR_BSR_LEN_DEFAULT 1029
`define JSR_CELLS_PER_PIN 3
`define JSR_CELL_IN 0
`define JSR_CELL_OUT 1
`define JSR_CELL_OE 2

`define JSR_ID_VER_MSB 31
`define JSR_ID_VER_LSB 28
`define JSR_ID_PART_MSB 27
`define JSR_ID_PART_LSB 12
`define JSR_ID_MFR_MSB 11
`define JSR_ID_MFR_LSB 1
`define JSR_ID_ONE_BIT 0

`endif

/* File: common/jsr_pkg.sv */
// types shared by the scan register set
package jsr_pkg;

	typedef enum logic [15:0] {
		JSR_RESET = 16'h0001,
		JSR_IDLE = 16'h0002,
		JSR_SEL_DR = 16'h0004,
		JSR_CAP_DR = 16'h0008,
		JSR_SH_DR = 16'h0010,
		JSR_EX1_DR = 16'h0020,
		JSR_PAU_DR = 16'h0040,
		JSR_EX2_DR = 16'h0080,
		JSR_UPD_DR = 16'h0100,
		JSR_SEL_IR = 16'h0200,
		JSR_CAP_IR = 16'h0400,
		JSR_SH_IR = 16'h0800,
		JSR_EX1_IR = 16'h1000,
		JSR_PAU_IR = 16'h2000,
		JSR_EX2_IR = 16'h4000,
		JSR_UPD_IR = 16'h8000
	} jsr_tap_t;

	typedef enum logic [3:0] {
		JSR_DR_BYP = 4'h1,
		JSR_DR_ID = 4'h2,
		JSR_DR_USER = 4'h4,
		JSR_DR_BSR = 4'h8
	} jsr_dr_t;

endpackage

/* File: logic/jsr_scan_top.sv */
// test access port with instruction, bypass, identification, user-code and boundary-scan registers
//
// Operation
// - an enabled keeper on a pin wins over the high impedance that HIGHZ, CLAMP or EXTEST gives it.
// - the instruction register is 10 bits and keeps the last 10 bits shifted in during Shift-IR.
// - a 32-bit user-code register is captured and shifted out when selected.
// - the boundary-scan register length is a parameter of 1029, 1665 or 1941 cells.
// - the identification word is version 4, part number 16, manufacturer 11 and one trailing bit, msb first.
// - bit zero of the identification word is always one.
// - the identification word is stored with its leftmost written bit as bit 31.
// - bypass, HIGHZ and CLAMP put a single bypass stage between data in and data out.
// - the identification instruction shifts the identification word to data out.
// - under CLAMP the pins are driven from the boundary-scan update stages while bypass is in the path.
// - the user-code instruction selects the user-code register as data register.
`timescale 1ns/10ps
`include "jsr_defines.svh"
module jsr_scan_top #(
	parameter int BSR_LEN = `JSR_BSR_LEN_DEFAULT,
	parameter logic [3:0] ID_VERSION = 4'h1, // arbitrary value
	parameter logic [15:0] ID_PART = 16'h5a5a, // arbitrary value
	parameter logic [10:0] ID_MFR = 11'h155, // arbitrary value
	localparam int NP = BSR_LEN / `JSR_CELLS_PER_PIN
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic TCK,
	input wire logic TMS,
	input wire logic TDI,
	output logic TDO,
	output logic TDO_OE,
	input wire logic [31:0] USER_CODE,
	input wire logic [NP-1:0] CORE_OUT,
	input wire logic [NP-1:0] CORE_OE,
	input wire logic [NP-1:0] PAD_IN,
	input wire logic [NP-1:0] KEEP_EN,
	output logic [NP-1:0] PAD_OUT,
	output logic [NP-1:0] PAD_OE,
	output logic [NP-1:0] PAD_KEEP
);

	localparam int IRL = `JSR_IR_LEN;
	localparam int WL = `JSR_WORD_LEN;

	logic [NP+2:0] sync_q;
	logic tck_s, tms_s, tdi_s, tck_d_reg, tck_rise, tck_fall;
	logic [NP-1:0] pad_s;
	jsr_pkg::jsr_tap_t state_reg;
	jsr_pkg::jsr_dr_t dr_sel;
	logic [IRL-1:0] ir_sh_reg, ir_reg;
	logic [WL-1:0] w_sh_reg, id_word;
	logic byp_reg;
	logic [BSR_LEN-1:0] bsr_sh_reg, bsr_upd_reg, bsr_cap;
	logic test_drive, test_hiz;
	logic [NP-1:0] oe_next, out_next;

	// standard tap state walk, one step per test-clock rise
	function automatic jsr_pkg::jsr_tap_t jsr_next(input jsr_pkg::jsr_tap_t s, input logic m);
		case (s)
			jsr_pkg::JSR_RESET: jsr_next = m ? jsr_pkg::JSR_RESET : jsr_pkg::JSR_IDLE;
			jsr_pkg::JSR_IDLE: jsr_next = m ? jsr_pkg::JSR_SEL_DR : jsr_pkg::JSR_IDLE;
			jsr_pkg::JSR_SEL_DR: jsr_next = m ? jsr_pkg::JSR_SEL_IR : jsr_pkg::JSR_CAP_DR;
			jsr_pkg::JSR_CAP_DR: jsr_next = m ? jsr_pkg::JSR_EX1_DR : jsr_pkg::JSR_SH_DR;
			jsr_pkg::JSR_SH_DR: jsr_next = m ? jsr_pkg::JSR_EX1_DR : jsr_pkg::JSR_SH_DR;
			jsr_pkg::JSR_EX1_DR: jsr_next = m ? jsr_pkg::JSR_UPD_DR : jsr_pkg::JSR_PAU_DR;
			jsr_pkg::JSR_PAU_DR: jsr_next = m ? jsr_pkg::JSR_EX2_DR : jsr_pkg::JSR_PAU_DR;
			jsr_pkg::JSR_EX2_DR: jsr_next = m ? jsr_pkg::JSR_UPD_DR : jsr_pkg::JSR_SH_DR;
			jsr_pkg::JSR_UPD_DR: jsr_next = m ? jsr_pkg::JSR_SEL_DR : jsr_pkg::JSR_IDLE;
			jsr_pkg::JSR_SEL_IR: jsr_next = m ? jsr_pkg::JSR_RESET : jsr_pkg::JSR_CAP_IR;
			jsr_pkg::JSR_CAP_IR: jsr_next = m ? jsr_pkg::JSR_EX1_IR : jsr_pkg::JSR_SH_IR;
			jsr_pkg::JSR_SH_IR: jsr_next = m ? jsr_pkg::JSR_EX1_IR : jsr_pkg::JSR_SH_IR;
			jsr_pkg::JSR_EX1_IR: jsr_next = m ? jsr_pkg::JSR_UPD_IR : jsr_pkg::JSR_PAU_IR;
			jsr_pkg::JSR_PAU_IR: jsr_next = m ? jsr_pkg::JSR_EX2_IR : jsr_pkg::JSR_PAU_IR;
			jsr_pkg::JSR_EX2_IR: jsr_next = m ? jsr_pkg::JSR_UPD_IR : jsr_pkg::JSR_SH_IR;
			jsr_pkg::JSR_UPD_IR: jsr_next = m ? jsr_pkg::JSR_SEL_DR : jsr_pkg::JSR_IDLE;
			default: jsr_next = jsr_pkg::JSR_RESET;
		endcase
	endfunction

	// instruction to data register; unknown codes fall back to bypass
	function automatic jsr_pkg::jsr_dr_t jsr_dr_of(input logic [IRL-1:0] ir);
		case (ir)
			`JSR_OP_IDCODE: jsr_dr_of = jsr_pkg::JSR_DR_ID;
			`JSR_OP_USERCODE: jsr_dr_of = jsr_pkg::JSR_DR_USER;
			`JSR_OP_EXTEST, `JSR_OP_SAMPLE: jsr_dr_of = jsr_pkg::JSR_DR_BSR;
			default: jsr_dr_of = jsr_pkg::JSR_DR_BYP;
		endcase
	endfunction

	// link pins and pad inputs come from outside the MCLK domain
	jsr_sync #(.WIDTH(NP + 3)) u_sync (
		.clk(MCLK),
		.rst_n(RSTN),
		.d({PAD_IN, TDI, TMS, TCK}),
		.q(sync_q)
	);

	assign tck_s = sync_q[0];
	assign tms_s = sync_q[1];
	assign tdi_s = sync_q[2];
	assign pad_s = sync_q[NP+2:3];
	// tms and tdi pass the same two stages, so they line up with the sampled edge
	assign tck_rise = tck_s & ~tck_d_reg;
	assign tck_fall = ~tck_s & tck_d_reg;
	assign dr_sel = jsr_dr_of(ir_reg);
	assign id_word = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
	assign test_drive = (ir_reg == `JSR_OP_EXTEST) || (ir_reg == `JSR_OP_CLAMP);
	assign test_hiz = (ir_reg == `JSR_OP_HIGHZ);

	// edge finder on the synchronised test clock
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			tck_d_reg <= 1'b0;
		else
			tck_d_reg <= tck_s;
	end

	// tap state
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			state_reg <= jsr_pkg::JSR_RESET;
		else if (tck_rise)
			state_reg <= jsr_next(state_reg, tms_s);
	end

	// instruction path; test-logic-reset falls back to identification
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ir_sh_reg <= `JSR_IR_CAPTURE;
			ir_reg <= `JSR_OP_IDCODE;
		end
		else if (tck_rise)
		begin
			case (state_reg)
				jsr_pkg::JSR_RESET: ir_reg <= `JSR_OP_IDCODE;
				jsr_pkg::JSR_CAP_IR: ir_sh_reg <= `JSR_IR_CAPTURE;
				jsr_pkg::JSR_SH_IR: ir_sh_reg <= {tdi_s, ir_sh_reg[IRL-1:1]};
				jsr_pkg::JSR_UPD_IR: ir_reg <= ir_sh_reg;
				default: ir_reg <= ir_reg;
			endcase
		end
	end

	// boundary capture: per pin an input cell, an output cell and an enable cell
	always_comb
	begin
		bsr_cap = '0;
		for (int i = 0; i < NP; i++)
		begin
			bsr_cap[i*`JSR_CELLS_PER_PIN+`JSR_CELL_IN] = pad_s[i];
			bsr_cap[i*`JSR_CELLS_PER_PIN+`JSR_CELL_OUT] = CORE_OUT[i];
			bsr_cap[i*`JSR_CELLS_PER_PIN+`JSR_CELL_OE] = CORE_OE[i];
		end
	end

	// data registers; one word shifter serves both identification and user code
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			byp_reg <= 1'b0;
			w_sh_reg <= '0;
			bsr_sh_reg <= '0;
			bsr_upd_reg <= '0;
		end
		else if (tck_rise)
		begin
			case (state_reg)
				jsr_pkg::JSR_CAP_DR:
				begin
					byp_reg <= 1'b0;
					if (dr_sel == jsr_pkg::JSR_DR_ID)
						w_sh_reg <= id_word;
					else if (dr_sel == jsr_pkg::JSR_DR_USER)
						w_sh_reg <= USER_CODE;
					if (dr_sel == jsr_pkg::JSR_DR_BSR)
						bsr_sh_reg <= bsr_cap;
				end
				jsr_pkg::JSR_SH_DR:
				begin
					if (dr_sel == jsr_pkg::JSR_DR_BYP)
						byp_reg <= tdi_s;
					else if (dr_sel == jsr_pkg::JSR_DR_BSR)
						bsr_sh_reg <= {tdi_s, bsr_sh_reg[BSR_LEN-1:1]};
					else
						w_sh_reg <= {tdi_s, w_sh_reg[WL-1:1]};
				end
				jsr_pkg::JSR_UPD_DR:
				begin
					if (dr_sel == jsr_pkg::JSR_DR_BSR)
						bsr_upd_reg <= bsr_sh_reg;
				end
				default: byp_reg <= byp_reg;
			endcase
		end
	end

	// data out changes on the falling test-clock edge so the far end samples a settled bit
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			TDO <= 1'b0;
			TDO_OE <= 1'b0;
		end
		else if (tck_fall)
		begin
			TDO_OE <= (state_reg == jsr_pkg::JSR_SH_DR) || (state_reg == jsr_pkg::JSR_SH_IR);
			if (state_reg == jsr_pkg::JSR_SH_IR)
				TDO <= ir_sh_reg[0];
			else if (dr_sel == jsr_pkg::JSR_DR_BYP)
				TDO <= byp_reg;
			else if (dr_sel == jsr_pkg::JSR_DR_BSR)
				TDO <= bsr_sh_reg[0];
			else
				TDO <= w_sh_reg[0];
		end
	end

	// pad steering: update stages in extest and clamp, all off in highz
	always_comb
	begin
		for (int i = 0; i < NP; i++)
		begin
			out_next[i] = test_drive ? bsr_upd_reg[i*`JSR_CELLS_PER_PIN+`JSR_CELL_OUT] : CORE_OUT[i];
			oe_next[i] = test_hiz ? 1'b0 :
				(test_drive ? bsr_upd_reg[i*`JSR_CELLS_PER_PIN+`JSR_CELL_OE] : CORE_OE[i]);
		end
	end

	// keeper stays live whenever the pad is released and KEEP_EN is set, so a test hi-z never floats a kept pin
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			PAD_OUT <= '0;
			PAD_OE <= '0;
			PAD_KEEP <= '0;
		end
		else
		begin
			PAD_OUT <= out_next;
			PAD_OE <= oe_next;
			PAD_KEEP <= KEEP_EN & ~oe_next;
		end
	end

	default clocking @(posedge MCLK); endclocking
	default disable iff (!RSTN);

	sequence s_rise_in(jsr_pkg::jsr_tap_t st);
		tck_rise && (state_reg == st);
	endsequence
	sequence s_shift_dr_sel(jsr_pkg::jsr_dr_t d);
		s_rise_in(jsr_pkg::JSR_SH_DR) ##0 (dr_sel == d);
	endsequence

	property p_keep_wins;
		test_hiz |=> (PAD_OE == '0) && (PAD_KEEP == $past(KEEP_EN));
	endproperty
	a_keep_wins: assert property (p_keep_wins) else $error("keeper not engaged under highz");
	property p_ir_shift;
		s_rise_in(jsr_pkg::JSR_SH_IR) |=> ir_sh_reg == {$past(tdi_s), $past(ir_sh_reg[IRL-1:1])};
	endproperty
	a_ir_shift: assert property (p_ir_shift) else $error("instruction shift wrong");
	property p_user_cap;
		s_rise_in(jsr_pkg::JSR_CAP_DR) ##0 (dr_sel == jsr_pkg::JSR_DR_USER) |=> w_sh_reg == $past(USER_CODE);
	endproperty
	a_user_cap: assert property (p_user_cap) else $error("user code not captured");
	property p_bsr_shift;
		s_shift_dr_sel(jsr_pkg::JSR_DR_BSR) |=> bsr_sh_reg == {$past(tdi_s), $past(bsr_sh_reg[BSR_LEN-1:1])};
	endproperty
	a_bsr_shift: assert property (p_bsr_shift) else $error("boundary shift wrong");
	property p_id_cap;
		s_rise_in(jsr_pkg::JSR_CAP_DR) ##0 (dr_sel == jsr_pkg::JSR_DR_ID) |=>
			(w_sh_reg[`JSR_ID_VER_MSB:`JSR_ID_VER_LSB] == ID_VERSION) &&
			(w_sh_reg[`JSR_ID_PART_MSB:`JSR_ID_PART_LSB] == ID_PART) &&
			(w_sh_reg[`JSR_ID_MFR_MSB:`JSR_ID_MFR_LSB] == ID_MFR) && w_sh_reg[`JSR_ID_ONE_BIT];
	endproperty
	a_id_cap: assert property (p_id_cap) else $error("identification word wrong");
	// a fall in shift-dr under bypass shows the single stage on data out
	property p_bypass_path;
		tck_fall && (state_reg == jsr_pkg::JSR_SH_DR) && (dr_sel == jsr_pkg::JSR_DR_BYP) |=> TDO == $past(byp_reg);
	endproperty
	a_bypass_path: assert property (p_bypass_path) else $error("bypass bit not on data out");
	// pin 0 follows its update stages one cycle later, even on the cycle the instruction leaves clamp
	property p_clamp_pins;
		(ir_reg == `JSR_OP_CLAMP) |-> (dr_sel == jsr_pkg::JSR_DR_BYP) ##1
			(PAD_OUT[0] == $past(bsr_upd_reg[`JSR_CELL_OUT])) && (PAD_OE[0] == $past(bsr_upd_reg[`JSR_CELL_OE]));
	endproperty
	a_clamp_pins: assert property (p_clamp_pins) else $error("clamp not holding update value");
	property p_user_sel;
		s_shift_dr_sel(jsr_pkg::JSR_DR_USER) |=> w_sh_reg == {$past(tdi_s), $past(w_sh_reg[WL-1:1])};
	endproperty
	a_user_sel: assert property (p_user_sel) else $error("user code register not in scan path");
	property p_tdo_fall;
		tck_fall && (state_reg == jsr_pkg::JSR_SH_DR) && (dr_sel == jsr_pkg::JSR_DR_ID) |=>
			(TDO == $past(w_sh_reg[0])) && TDO_OE;
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("data out not lsb on falling edge");
endmodule

/* File: logic/jsr_sync.sv */
// two-stage synchroniser for inputs from outside the MCLK domain
`timescale 1ns/10ps
module jsr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= '0;
			q <= '0;
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule

/* File: verif/jsr_ctl_model.sv */
// behavioural test controller that drives the scan link
`timescale 1ns/10ps
module jsr_ctl_model (
	input wire logic clk,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// link parks with its clock low between frames
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// one 400 ns test-clock period; data out is read late in the high phase, where it is settled
	task automatic tick(input logic m, input logic d, output logic q);
		@(posedge clk);
		tms <= m;
		tdi <= d;
		repeat (3) @(posedge clk);
		tck <= 1'b1;
		repeat (3) @(posedge clk);
		q = tdo;
		@(posedge clk);
		tck <= 1'b0;
		tdi <= ~d; // stale data is never left looking valid
	endtask

	// five ticks with mode high reach test-logic-reset from any state, then park in idle
	task automatic to_idle();
		logic q;
		repeat (5) tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask

	// from idle into a shift state, move n bits lsb first, update and return to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = '0;
		tick(1'b1, 1'b0, q);
		if (ir)
			tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++)
		begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
		end
		tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask
endmodule

/* File: verif/tb.sv */
// self-checking bench for the scan register set
`timescale 1ns/10ps
`include "jsr_defines.svh"
module tb;
	localparam int NP = 3;
	localparam logic [3:0] VER = 4'h9; // arbitrary value
	localparam logic [15:0] PART = 16'h3c71; // arbitrary value
	localparam logic [10:0] MFR = 11'h4d2; // arbitrary value
	logic mclk, rstn, tck, tms, tdi, tdo, tdo_oe;
	logic [31:0] user_code, dout, din;
	logic [NP-1:0] core_out, core_oe, pad_in, keep_en, pad_out, pad_oe, pad_keep, p_out, p_oe;
	int seed, bad_count, n_tests;

	// short chain of three pins keeps each scan brief
	jsr_scan_top #(.BSR_LEN(9), .ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR)) u_jsr_scan_top (
		.MCLK(mclk), .RSTN(rstn), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe),
		.USER_CODE(user_code), .CORE_OUT(core_out), .CORE_OE(core_oe), .PAD_IN(pad_in),
		.KEEP_EN(keep_en), .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_KEEP(pad_keep));
	jsr_ctl_model u_ctl (.clk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	function automatic logic [31:0] exp_id();
		return {VER, PART, MFR, 1'b1};
	endfunction

	// pick cell k of every pin out of a 9-cell image
	function automatic logic [NP-1:0] cells(input logic [8:0] img, input int k);
		logic [NP-1:0] r;
		for (int i = 0; i < NP; i++)
			r[i] = img[3 * i + k];
		return r;
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// pads and the data-out enable are read off the sampling edge, after the last fall has landed
	task automatic chk_pads(input logic [NP-1:0] o, input logic [NP-1:0] e);
		repeat (4) @(negedge mclk);
		chk("pad data", 32'(o), 32'(pad_out));
		chk("pad enable", 32'(e), 32'(pad_oe));
		chk("pad keeper", 32'(keep_en & ~e), 32'(pad_keep));
		chk("idle data out enable", 32'h0, 32'(tdo_oe));
	endtask

	// one-stage path: the captured zero leads, then data in delayed by one bit
	task automatic byp(input logic [9:0] op);
		logic [31:0] d;
		d = $random(seed);
		u_ctl.scan(1'b1, 10, 32'(op), dout);
		u_ctl.scan(1'b0, 32, d, dout);
		chk("bypass path", {d[30:0], 1'b0}, dout);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		seed = 69;
		bad_count = 0;
		n_tests = 0;
		rstn = 1'b0;
		user_code = 32'h0;
		core_out = '0;
		core_oe = '0;
		pad_in = '0;
		keep_en = '0;
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		// instruction after reset selects the identification word
		u_ctl.to_idle();
		u_ctl.scan(1'b0, 32, 32'h0, dout);
		chk("id word", exp_id(), dout);
		for (int r = 0; r < 4; r++)
		begin
			@(posedge mclk);
			user_code <= $random(seed);
			core_out <= NP'($random(seed));
			core_oe <= NP'($random(seed));
			pad_in <= NP'($random(seed));
			keep_en <= (r == 0) ? 3'h7 : NP'($random(seed));
			din = $random(seed);
			u_ctl.scan(1'b1, 10, 32'(`JSR_OP_USERCODE), dout);
			chk("ir capture", 32'(`JSR_IR_CAPTURE), dout);
			u_ctl.scan(1'b0, 32, 32'h0, dout);
			chk("user code", user_code, dout);
			chk_pads(core_out, core_oe);
			// capture inputs, pass through after the chain, and leave the last bits preloaded
			u_ctl.scan(1'b1, 10, 32'(`JSR_OP_SAMPLE), dout);
			u_ctl.scan(1'b0, 32, din, dout);
			chk("input cells", 32'(pad_in), 32'(cells(dout[8:0], 0)));
			chk("pass through", 32'(din[22:0]), 32'(dout[31:9]));
			p_out = cells(din[31:23], 1);
			p_oe = cells(din[31:23], 2);
			u_ctl.scan(1'b1, 10, 32'(`JSR_OP_EXTEST), dout);
			chk_pads(p_out, p_oe);
			byp(`JSR_OP_CLAMP);
			chk_pads(p_out, p_oe);
			byp(`JSR_OP_HIGHZ);
			repeat (4) @(negedge mclk);
			chk("highz enable", 32'h0, 32'(pad_oe));
			chk("highz keeper", 32'(keep_en), 32'(pad_keep));
			byp(`JSR_OP_BYPASS);
			byp(10'h2c4);
		end
		give_verdict();
	end

	// cut a hang short well past the expected span of the run
	initial
	begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		$display("[FAIL] watchdog expected completion seen timeout");
		give_verdict();
	end
endmodule
